// ### hdl/dis_pkg.sv
// Purpose: shared constants and types for the memory init sequencer
// Assumes: 40 MHz pclk, APB register access at word offsets
// Notes: timing figures kept in ns except the DLL lock budget, cycle counts derived from them
package dis_pkg;
  localparam int CLK_NS = 25;
  // power-up hold with clock enable low, in ns
  localparam int POWERUP_NS = 200000;
  localparam int POWERUP_CYC = (POWERUP_NS + CLK_NS - 1) / CLK_NS;
  // DLL lock budget, in clock cycles
  localparam int DLL_LOCK_CYC = 200;
  // default minimum waits in ns (plain values, tunable)
  localparam int PRECHARGE_NS = 15;
  localparam int MODE_SET_NS = 10;
  localparam int REFRESH_CYCLE_NS = 75;
  localparam int PRECHARGE_CYC = (PRECHARGE_NS + CLK_NS - 1) / CLK_NS;
  localparam int MODE_SET_CYC = (MODE_SET_NS + CLK_NS - 1) / CLK_NS;
  localparam int REFRESH_CYC = (REFRESH_CYCLE_NS + CLK_NS - 1) / CLK_NS;
  // register offsets
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_MODE = 8'h04;
  localparam logic [7:0] REG_STATUS = 8'h08;
  // control field positions
  localparam int CTRL_START = 0;
  localparam int CTRL_DRIVE = 1;
  localparam int CTRL_FINAL_MRS = 2;
  localparam int CTRL_RELOCK = 3;
  // mode register bit positions
  localparam int DLL_DISABLE_POS = 0;
  localparam int DRIVE_POS = 1;
  localparam int DLL_RESET_POS = 8;
  localparam logic [12:0] MODE_RESET = 13'h0032;
  // command encodings {cs_n, ras_n, cas_n, we_n}
  localparam logic [3:0] CMD_NOP = 4'h7;
  localparam logic [3:0] CMD_PRECHARGE = 4'h2;
  localparam logic [3:0] CMD_REFRESH = 4'h1;
  localparam logic [3:0] CMD_LOAD_MODE = 4'h0;
  localparam int A10_POS = 10;
  // command bus to the memory
  typedef struct packed {
    logic cke;
    logic [3:0] cmd;
    logic [1:0] bank;
    logic [12:0] addr;
  } dis_cmd_t;
endpackage

// ### hdl/dis_init_seq.sv
// Purpose: host side power-up sequencer driving a DDR memory module
// Assumes: software starts it over APB; memory clock is pclk
// Notes: waits counted in whole cycles, NOP on every idle cycle
// How it works
// [R01] hold clock enable low 200us, then NOP
// [R02] precharge all, then wait precharge period
// [R03] extended mode: DLL on, drive bit chosen
// [R04] wait mode set delay after each load
// [R05] base mode load with DLL reset set
// [R06] 200 cycles from DLL reset to reads
// [R07] second precharge all, then wait
// [R08] two refreshes, each followed by refresh time
// [R09] optional load clearing DLL reset bit
// [R10] memory accepts commands after sequence ends
// [R11] clock enable high across each refresh
// [R12] clock change: DLL reset then 200 cycles
// [R13] whole-cycle waits, NOP when idle
`timescale 1ns/10ps
`default_nettype none
module dis_init_seq
  import dis_pkg::*;
#(
  parameter int POWERUP_CYCLES = POWERUP_CYC
) (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // memory command pins
  output var dis_pkg::dis_cmd_t mem_cmd
);
  import dis_pkg::*;

  // elaboration check: the hold must fit the 18-bit wait counter
  if (POWERUP_CYCLES < 1 || POWERUP_CYCLES > 262144) begin : g_bad_hold
    $error("POWERUP_CYCLES out of range");
  end

  typedef enum logic [3:0] {S_IDLE, S_POWER, S_WAKE, S_PRE1, S_EMR, S_MR,
    S_PRE2, S_REF1, S_REF2, S_MR2, S_READY} dis_state_t;

  dis_state_t state; // sequence position
  logic [17:0] wait_cnt; // remaining idle cycles
  logic [7:0] dll_cnt; // cycles since last DLL reset
  logic [12:0] mode_bits; // operating parameters
  logic ctrl_drive; // reduced drive select
  logic ctrl_final; // issue closing mode load
  logic start_pulse; // software start
  logic relock_pulse; // software relock after clock change
  logic busy;
  logic apb_wr;

  assign apb_wr = psel && penable && pwrite;
  assign busy = (state != S_IDLE) && (state != S_READY);

  // builds a command word; clock enable is always set high in it
  function automatic dis_cmd_t mk(input logic [3:0] c, input logic [1:0] b,
                                  input logic [12:0] a);
    dis_cmd_t r;
    r.cke = 1'b1;
    r.cmd = c;
    r.bank = b;
    r.addr = a;
    return r;
  endfunction

  // register writes; start and relock bits self-clear as pulses
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mode_bits <= MODE_RESET;
      ctrl_drive <= 1'b0;
      ctrl_final <= 1'b1;
      start_pulse <= 1'b0;
      relock_pulse <= 1'b0;
    end else begin
      start_pulse <= 1'b0;
      relock_pulse <= 1'b0;
      if (apb_wr && paddr == REG_CTRL) begin
        start_pulse <= pwdata[CTRL_START];
        ctrl_drive <= pwdata[CTRL_DRIVE];
        ctrl_final <= pwdata[CTRL_FINAL_MRS];
        relock_pulse <= pwdata[CTRL_RELOCK];
      end else if (apb_wr && paddr == REG_MODE && !busy) begin
        mode_bits <= pwdata[12:0];
      end
    end
  end

  // apb answers: zero wait states, error on unmapped address
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
      pready <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready <= psel && !penable;
      pslverr <= psel && !penable && paddr != REG_CTRL &&
                 paddr != REG_MODE && paddr != REG_STATUS;
      case (paddr)
        REG_CTRL: prdata <= {29'h0, ctrl_final, ctrl_drive, 1'b0};
        REG_MODE: prdata <= {19'h0, mode_bits};
        // ready only once the closing wait has run out as well
        REG_STATUS: prdata <= {22'h0, dll_cnt == 8'(DLL_LOCK_CYC),
                               state == S_READY && wait_cnt == 18'h0, // [R10]
                               4'(state), 4'h0};
        default: prdata <= 32'h0000_0000;
      endcase
    end
  end

  // DLL lock counter; restarts on every DLL reset load
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      dll_cnt <= 8'h00;
    end else if (mem_cmd.cmd == CMD_LOAD_MODE && mem_cmd.bank == 2'h0 &&
                 mem_cmd.addr[DLL_RESET_POS]) begin
      dll_cnt <= 8'h01; // [R06] [R12]
    end else if (dll_cnt != 8'h00 && dll_cnt != 8'(DLL_LOCK_CYC)) begin
      // stays at zero until the first DLL reset load, so no false lock
      dll_cnt <= dll_cnt + 8'h01;
    end
  end

  // sequencer: one command then a counted NOP wait
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state <= S_IDLE;
      wait_cnt <= 18'h0;
      mem_cmd <= '{cke: 1'b0, cmd: CMD_NOP, bank: 2'h0, addr: 13'h0};
    end else begin
      mem_cmd.cmd <= CMD_NOP; // [R13]
      mem_cmd.bank <= 2'h0;
      mem_cmd.addr <= 13'h0;
      if (wait_cnt != 18'h0) begin
        wait_cnt <= wait_cnt - 18'h1; // [R02] [R04] [R07] [R08] [R11]
      end else begin
        case (state)
          S_IDLE: begin
            if (start_pulse) begin
              state <= S_POWER;
              mem_cmd.cke <= 1'b0; // [R01]
              wait_cnt <= 18'(POWERUP_CYCLES - 1);
            end
          end
          S_POWER: begin
            mem_cmd.cke <= 1'b1; // [R01]
            state <= S_WAKE;
          end
          S_WAKE: begin
            mem_cmd <= mk(CMD_PRECHARGE, 2'h0, 13'(1 << A10_POS)); // [R02]
            wait_cnt <= 18'(PRECHARGE_CYC);
            state <= S_EMR;
          end
          S_EMR: begin
            mem_cmd <= mk(CMD_LOAD_MODE, 2'h1,
                          13'({ctrl_drive, 1'b0})); // [R03]
            wait_cnt <= 18'(MODE_SET_CYC); // [R04]
            state <= S_MR;
          end
          S_MR: begin
            mem_cmd <= mk(CMD_LOAD_MODE, 2'h0,
                          mode_bits | 13'(1 << DLL_RESET_POS)); // [R05]
            wait_cnt <= 18'(MODE_SET_CYC); // [R04]
            state <= S_PRE2;
          end
          S_PRE2: begin
            mem_cmd <= mk(CMD_PRECHARGE, 2'h0, 13'(1 << A10_POS)); // [R07]
            wait_cnt <= 18'(PRECHARGE_CYC);
            state <= S_REF1;
          end
          S_REF1: begin
            mem_cmd <= mk(CMD_REFRESH, 2'h0, 13'h0); // [R08]
            wait_cnt <= 18'(REFRESH_CYC);
            state <= S_REF2;
          end
          S_REF2: begin
            mem_cmd <= mk(CMD_REFRESH, 2'h0, 13'h0); // [R08]
            wait_cnt <= 18'(REFRESH_CYC);
            state <= ctrl_final ? S_MR2 : S_READY;
          end
          S_MR2: begin
            mem_cmd <= mk(CMD_LOAD_MODE, 2'h0,
                          mode_bits & ~13'(1 << DLL_RESET_POS)); // [R09]
            wait_cnt <= 18'(MODE_SET_CYC);
            state <= S_READY;
          end
          S_READY: begin
            // ready flag means the memory may take any command but a read, which waits for the DLL lock flag
            if (relock_pulse) begin
              mem_cmd <= mk(CMD_LOAD_MODE, 2'h0,
                            mode_bits | 13'(1 << DLL_RESET_POS)); // [R12]
              wait_cnt <= 18'(MODE_SET_CYC);
            end else if (start_pulse) begin
              // restart skips the power hold: clock enable is already up
              state <= S_WAKE;
            end
          end
          default: state <= S_IDLE;
        endcase
      end
    end
  end

  // clock enable stays high on each refresh cycle and the two cycles after it
  property p_cke_refresh;
    @(posedge pclk) disable iff (!presetn)
      mem_cmd.cmd == CMD_REFRESH |-> mem_cmd.cke [*3];
  endproperty
  a_cke_refresh: assert property (p_cke_refresh) // [R11]
    else $error("clock enable dropped during refresh");

  // commands are followed by a NOP
  property p_nop_after;
    @(posedge pclk) disable iff (!presetn)
      mem_cmd.cmd != CMD_NOP |=> mem_cmd.cmd == CMD_NOP;
  endproperty
  a_nop_after: assert property (p_nop_after) // [R13]
    else $error("command not followed by NOP");

  // extended load keeps DLL enabled and higher bits clear
  property p_emr_bits;
    @(posedge pclk) disable iff (!presetn)
      (mem_cmd.cmd == CMD_LOAD_MODE && mem_cmd.bank == 2'h1) |->
        mem_cmd.addr[DLL_DISABLE_POS] == 1'b0 && mem_cmd.addr[12:2] == 11'h0;
  endproperty
  a_emr_bits: assert property (p_emr_bits) // [R03]
    else $error("extended mode value illegal");

  // clock enable low for the first cycle of power wait
  property p_power_low;
    @(posedge pclk) disable iff (!presetn)
      $rose(state == S_POWER) |-> !mem_cmd.cke;
  endproperty
  a_power_low: assert property (p_power_low) // [R01]
    else $error("clock enable high during power wait");

  // ready reached only after DLL reset load
  property p_ready_dll;
    @(posedge pclk) disable iff (!presetn)
      $rose(state == S_READY) |-> dll_cnt != 8'h00;
  endproperty
  a_ready_dll: assert property (p_ready_dll) // [R05]
    else $error("ready without DLL reset");

  // base load during sequence carries DLL reset
  property p_mr_reset;
    @(posedge pclk) disable iff (!presetn)
      ($past(state) == S_MR && state == S_PRE2) |->
        mem_cmd.addr[DLL_RESET_POS];
  endproperty
  a_mr_reset: assert property (p_mr_reset) // [R05]
    else $error("base load lacks DLL reset");

  // closing load clears DLL reset
  property p_mr2_clear;
    @(posedge pclk) disable iff (!presetn)
      ($past(state) == S_MR2 && state == S_READY) |->
        !mem_cmd.addr[DLL_RESET_POS];
  endproperty
  a_mr2_clear: assert property (p_mr2_clear) // [R09]
    else $error("closing load keeps DLL reset");

  // mode load followed by at least one idle cycle
  property p_mrd_wait;
    @(posedge pclk) disable iff (!presetn)
      mem_cmd.cmd == CMD_LOAD_MODE |=> mem_cmd.cmd == CMD_NOP [*1];
  endproperty
  a_mrd_wait: assert property (p_mrd_wait) // [R04]
    else $error("mode set delay violated");
endmodule
`default_nettype wire

// ### sim/dis_mem_model.sv
// Purpose: behavioural memory module watching the command pins
// Assumes: one command per cycle, NOP on idle cycles
// Notes: counts spacing faults, logs every non-idle command
`timescale 1ns/10ps
`default_nettype none
module dis_mem_model #(
  parameter int POWERUP_CYCLES = dis_pkg::POWERUP_CYC
) (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // command pins from the controller
  input wire dis_pkg::dis_cmd_t mem_cmd,
  // observation
  output logic [7:0] viol_count,
  output logic seq_done
);
  import dis_pkg::*;
  dis_cmd_t log_q[$]; // commands in arrival order, read by the bench
  int low_n, hi_n, cyc, last_t, wait_n, ref_left, ref_n;
  // behavioural checker; blocking updates keep the bookkeeping short
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      {low_n, hi_n, cyc, last_t, wait_n, ref_left, ref_n} = '0;
      viol_count = 8'h00;
      seq_done = 1'b0;
      log_q.delete();
    end else begin
      cyc++;
      if (!mem_cmd.cke && ref_left > 0) viol_count++;
      if (!mem_cmd.cke) low_n++;
      if (ref_left > 0) ref_left--;
      if (mem_cmd.cmd !== CMD_NOP) begin
        // a command needs the full low hold and one high idle cycle
        if (hi_n == 0 || low_n < POWERUP_CYCLES) viol_count++;
        if (cyc - last_t < wait_n) viol_count++;
        case (mem_cmd.cmd)
          CMD_PRECHARGE: wait_n = PRECHARGE_CYC;
          CMD_LOAD_MODE: wait_n = MODE_SET_CYC;
          CMD_REFRESH: begin
            wait_n = REFRESH_CYC;
            ref_left = REFRESH_CYC;
            ref_n++;
          end
          default: viol_count++;
        endcase
        last_t = cyc;
        log_q.push_back(mem_cmd);
      end
      if (mem_cmd.cke) hi_n++;
      // ready for any command but a read (200 cycles from DLL reset) once two refreshes are seen and the last command's wait has run out
      seq_done = (ref_n >= 2) && (cyc - last_t >= wait_n);
    end
  end
endmodule
`default_nettype wire

// ### sim/tb.sv
// Purpose: self-checking bench for the init sequencer
// Assumes: shortened power-up hold, memory model on the pins
// Notes: random base mode values from a fixed seed
`timescale 1ns/10ps
`default_nettype none
`define CHK(n, e, g) begin total_checks++; if ((e) !== (g)) begin \
  fail_count++; $display("[FAIL] %s exp %0h got %0h", n, e, g); end end
module tb;
  import dis_pkg::*;
  localparam int PU = 10; // short hold keeps the run small
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, er;
  logic [7:0] paddr, viol_count;
  logic [31:0] pwdata, prdata, rd;
  dis_cmd_t mem_cmd, ex, got;
  logic seq_done, drv, fin;
  logic [12:0] mode;
  int fail_count, total_checks, cyc, seed, t0, n;
  dis_init_seq #(.POWERUP_CYCLES(PU)) dis_init_seq_inst (.pclk(pclk),
    .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .mem_cmd(mem_cmd));
  dis_mem_model #(.POWERUP_CYCLES(PU)) dis_mem_model_inst (.pclk(pclk),
    .presetn(presetn), .mem_cmd(mem_cmd), .viol_count(viol_count),
    .seq_done(seq_done));
  // free-running 40 MHz clock
  initial begin
    pclk = 1'b0;
    forever #12.5 pclk = ~pclk;
  end
  // cycle count doubles as the hang limit
  always @(posedge pclk) begin
    cyc++;
    if (cyc == 40000) begin
      fail_count++;
      end_sim();
    end
  end
  task end_sim;
    $display("checks %0d mismatches %0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  // one apb transfer; waits for pready however long it takes
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  // expected i-th command of the power-up sequence
  function dis_cmd_t exp_at(input int i);
    dis_cmd_t c;
    c = '0;
    c.cmd = CMD_PRECHARGE;
    c.addr[A10_POS] = 1'b1;
    if (i == 1) begin
      c.cmd = CMD_LOAD_MODE;
      c.bank = 2'h1;
      c.addr = 13'h0000;
      c.addr[DRIVE_POS] = drv;
    end
    if (i == 2 || i == 6) begin
      c.cmd = CMD_LOAD_MODE;
      c.addr = mode;
      c.addr[DLL_RESET_POS] = (i == 2);
    end
    if (i == 4 || i == 5) c.cmd = CMD_REFRESH;
    return c;
  endfunction
  initial begin
    {psel, penable, pwrite, presetn} = 4'h0;
    {paddr, pwdata, cyc, fail_count, total_checks} = '0;
    seed = 90329;
    for (int run = 0; run < 2; run++) begin
      presetn <= 1'b0;
      repeat (10) @(posedge pclk);
      `CHK("cke", 1'b0, mem_cmd.cke)
      `CHK("cmd", CMD_NOP, mem_cmd.cmd)
      presetn <= 1'b1;
      @(posedge pclk);
      apb(1'b0, REG_MODE, 32'h0);
      `CHK("mode reset", 32'(MODE_RESET), rd)
      `CHK("mode err", 1'b0, er)
      apb(1'b0, 8'h0C, 32'h0);
      `CHK("unmapped err", 1'b1, er)
      mode = 13'($random(seed)) & 13'h1EFF;
      drv = 1'($random(seed));
      fin = (run == 0);
      apb(1'b1, REG_MODE, 32'(mode));
      apb(1'b1, REG_CTRL, {29'h0, fin, drv, 1'b1});
      // control reads back with the start pulse already gone
      apb(1'b0, REG_CTRL, 32'h0);
      `CHK("ctrl", {29'h0, fin, drv, 1'b0}, rd)
      apb(1'b1, REG_MODE, 32'(~mode));
      n = 0;
      do begin
        apb(1'b0, REG_STATUS, 32'h0);
        n++;
      end while (rd[8] !== 1'b1 && n < 500);
      `CHK("ready", 1'b1, rd[8])
      apb(1'b0, REG_MODE, 32'h0);
      `CHK("mode kept", 32'(mode), rd)
      `CHK("count", 6 + int'(fin), dis_mem_model_inst.log_q.size())
      for (int i = 0; i < dis_mem_model_inst.log_q.size(); i++) begin
        ex = exp_at(i);
        got = dis_mem_model_inst.log_q[i];
        `CHK("cmd", ex.cmd, got.cmd)
        if (ex.cmd == CMD_LOAD_MODE)
          `CHK("mode val", {ex.bank, ex.addr}, {got.bank, got.addr})
        if (ex.cmd == CMD_PRECHARGE)
          `CHK("a10", 1'b1, got.addr[A10_POS])
      end
      `CHK("spacing", 8'h00, viol_count)
      `CHK("mem ready", 1'b1, seq_done)
      apb(1'b1, REG_CTRL, 32'h8);
      t0 = cyc;
      apb(1'b0, REG_STATUS, 32'h0);
      `CHK("lock early", 1'b0, rd[9])
      n = 0;
      do begin
        apb(1'b0, REG_STATUS, 32'h0);
        n++;
      end while (rd[9] !== 1'b1 && n < 300);
      `CHK("lock flag", 1'b1, rd[9])
      `CHK("lock wait", 1'b1, cyc - t0 >= DLL_LOCK_CYC)
      got = dis_mem_model_inst.log_q[$];
      `CHK("relock cmd", CMD_LOAD_MODE, got.cmd)
      `CHK("relock bit", 1'b1, got.addr[DLL_RESET_POS])
      // restart from ready: precharge onward again, no closing load
      t0 = dis_mem_model_inst.log_q.size();
      apb(1'b1, REG_CTRL, 32'h1);
      do apb(1'b0, REG_STATUS, 32'h0); while (rd[8] !== 1'b1);
      `CHK("restart", t0 + 6, dis_mem_model_inst.log_q.size())
      `CHK("restart spacing", 8'h00, viol_count)
    end
    end_sim();
  end
endmodule
`default_nettype wire
